// File: pkg/acr_pkg.sv
// Constants, field layout and state encoding for the converter configuration port.
// Assumes a single 40 MHz clock and serial pins already synchronous to it.

package acr_pkg;

	localparam int unsigned CFG_W = 24;

	// Register select codes carried in the command byte.
	localparam logic [1:0] REG_COMM = 2'h0;
	localparam logic [1:0] REG_CFG  = 2'h1;
	localparam logic [1:0] REG_FILT = 2'h2;
	localparam logic [1:0] REG_DATA = 2'h3;

	localparam logic [23:0] CFG_RESET = 24'h00_0007;
	// Read-only port input bits are never stored.
	localparam logic [23:0] CFG_WR_MASK = 24'hff_f3ff;

	// Command byte fields.
	localparam int unsigned CMD_RW   = 6;
	localparam int unsigned CMD_STBY = 5;

	// Configuration word fields.
	localparam int unsigned F_SW_B   = 23;
	localparam int unsigned F_SW_A   = 22;
	localparam int unsigned F_EXC_C  = 20;
	localparam int unsigned F_EXC_B  = 18;
	localparam int unsigned F_EXC_A  = 16;
	localparam int unsigned F_D_DIG  = 15;
	localparam int unsigned F_C_DIG  = 14;
	localparam int unsigned F_B_EN   = 13;
	localparam int unsigned F_A_EN   = 12;
	localparam int unsigned F_D_DAT  = 11;
	localparam int unsigned F_C_DAT  = 10;
	localparam int unsigned F_B_DAT  = 9;
	localparam int unsigned F_A_DAT  = 8;

	// Transfer lengths minus one, in bits.
	localparam logic [4:0] LAST_BYTE = 5'h07;
	localparam logic [4:0] LAST_DATA = 5'h0f;
	localparam logic [4:0] LAST_CFG  = 5'h17;

	typedef enum logic [1:0] {
		ACR_ST_CMD   = 2'b00,
		ACR_ST_WRITE = 2'b01,
		ACR_ST_READ  = 2'b10
	} acr_state_e;

endpackage : acr_pkg

// File: rtl/acr_cfg_bank.sv
// Storage for the 24-bit configuration word and its read-back snapshot.
// Assumes write and snapshot strobes are single-cycle pulses from the serial front end.
`timescale 1ns/1ps
`default_nettype none

module acr_cfg_bank (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [23:0] wr_data,
	input  wire logic        snap_en,
	input  wire logic        port_c_in,
	input  wire logic        port_d_in,
	output logic      [23:0] cfg,
	output logic      [23:0] rd_data
);

	logic [23:0] cfg_r;
	logic [23:0] rd_r;
	wire  [23:0] cfg_nxt;
	wire  [23:0] rd_nxt;
	wire         c_in_bit;
	wire         d_in_bit;

	assign cfg_nxt = wr_data & acr_pkg::CFG_WR_MASK;
	// Input-only port bits report the pin only while enabled as digital inputs.
	assign c_in_bit = cfg_r[acr_pkg::F_C_DIG] & port_c_in;
	assign d_in_bit = cfg_r[acr_pkg::F_D_DIG] & port_d_in;
	assign rd_nxt   = {cfg_r[23:12], d_in_bit, c_in_bit, cfg_r[9:0]};

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfg_r <= acr_pkg::CFG_RESET;
		end else if (wr_en) begin
			cfg_r <= cfg_nxt;
		end
	end

	// Snapshot so a read stays coherent even if the pins move mid-transfer.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_r <= 24'h00_0000;
		end else if (snap_en) begin
			rd_r <= rd_nxt;
		end
	end

	assign cfg     = cfg_r;
	assign rd_data = rd_r;

	reset_val_a: assert property (@(posedge clk) !rst_b |=> cfg == acr_pkg::CFG_RESET)
		else $error("configuration word not at reset value after reset");

	cfg_store_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_en |=> cfg == ($past(wr_data) & acr_pkg::CFG_WR_MASK))
		else $error("configuration write not stored");

	cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!wr_en |=> $stable(cfg))
		else $error("configuration word changed without a write");

endmodule : acr_cfg_bank

`default_nettype wire

// File: rtl/acr_config_port.sv
// Serial command port, configuration word and the switch and excitation controls it drives.
// Assumes cs_b, sclk and din are synchronous to clk and sclk is far slower than clk.
`timescale 1ns/1ps
`default_nettype none

module acr_config_port (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       cs_b,
	input  wire logic       sclk,
	input  wire logic       din,
	output logic            dout,
	output logic            dout_oe,
	input  wire logic       port_c_in,
	input  wire logic       port_d_in,
	output logic            standby,
	output logic            low_switch_a_close,
	output logic            low_switch_b_close,
	output logic            switch_a_pin_out,
	output logic            switch_a_pin_oe,
	output logic            switch_b_pin_out,
	output logic            switch_b_pin_oe,
	output logic            excite_a_to_pin_a,
	output logic            excite_a_to_pin_b,
	output logic            excite_b_to_pin_a,
	output logic            excite_b_to_pin_b,
	output logic            excite_c_to_pin_a,
	output logic            excite_c_to_pin_b,
	output logic      [7:0] analog_config
);

	// Last bit index of a transfer to the given register.
	function automatic logic [4:0] last_bit(input logic [1:0] sel);
		case (sel)
			acr_pkg::REG_CFG:  last_bit = acr_pkg::LAST_CFG;
			acr_pkg::REG_DATA: last_bit = acr_pkg::LAST_DATA;
			default:           last_bit = acr_pkg::LAST_BYTE;
		endcase
	endfunction : last_bit

	// Route decode: bit 0 means first output pin, bit 1 means second; reserved gives neither.
	function automatic logic [1:0] route(input logic [1:0] code);
		case (code)
			2'b01:   route = 2'b01;
			2'b10:   route = 2'b10;
			default: route = 2'b00;
		endcase
	endfunction : route

	acr_pkg::acr_state_e state_r;
	acr_pkg::acr_state_e state_nxt;

	logic        sclk_d_r;
	logic [4:0]  bit_cnt_r;
	logic [4:0]  bit_cnt_nxt;
	logic [22:0] shift_r;
	logic [1:0]  sel_r;
	logic [1:0]  sel_nxt;
	logic        standby_r;
	logic        standby_nxt;
	logic        dout_r;

	wire         sclk_rise;
	wire         sclk_fall;
	wire [7:0]   cmd_byte;
	wire [23:0]  wr_word;
	wire         cmd_done;
	wire         cmd_write_cmd;
	wire         cmd_read;
	wire         wr_last;
	wire         cfg_wr;
	wire         snap;
	wire [23:0]  cfg;
	wire [23:0]  cfg_rd;
	wire         rd_bit;
	wire [1:0]   route_a;
	wire [1:0]   route_b;
	wire [1:0]   route_c;

	// Edges are seen in the clk domain, so sclk must stay several clocks in each level.
	assign sclk_rise = ~cs_b & sclk & ~sclk_d_r;
	assign sclk_fall = ~cs_b & ~sclk & sclk_d_r;

	// A leading one in the command slot is a wait bit and is not counted.
	assign cmd_done      = (state_r == acr_pkg::ACR_ST_CMD) & sclk_rise & (bit_cnt_r == acr_pkg::LAST_BYTE);
	assign cmd_byte      = {shift_r[6:0], din};
	assign cmd_read      = cmd_byte[acr_pkg::CMD_RW];
	assign cmd_write_cmd = ~cmd_read & (cmd_byte[1:0] == acr_pkg::REG_COMM);
	assign wr_word       = {shift_r, din};

	assign wr_last = (state_r == acr_pkg::ACR_ST_WRITE) & sclk_rise & (bit_cnt_r == 5'h00);
	assign cfg_wr  = wr_last & (sel_r == acr_pkg::REG_CFG);
	assign snap    = cmd_done & cmd_read;

	always_comb begin
		state_nxt   = state_r;
		bit_cnt_nxt = bit_cnt_r;
		sel_nxt     = sel_r;
		standby_nxt = standby_r;
		if (cs_b) begin
			state_nxt   = acr_pkg::ACR_ST_CMD;
			bit_cnt_nxt = 5'h00;
		end else if (sclk_rise) begin
			case (state_r)
				acr_pkg::ACR_ST_CMD: begin
					if (cmd_done) begin
						standby_nxt = cmd_byte[acr_pkg::CMD_STBY];
						sel_nxt     = cmd_byte[1:0];
						bit_cnt_nxt = cmd_write_cmd ? 5'h00 : last_bit(cmd_byte[1:0]);
						if (cmd_write_cmd) begin
							state_nxt = acr_pkg::ACR_ST_CMD;
						end else if (cmd_read) begin
							state_nxt = acr_pkg::ACR_ST_READ;
						end else begin
							state_nxt = acr_pkg::ACR_ST_WRITE;
						end
					end else if (bit_cnt_r != 5'h00 || !din) begin
						bit_cnt_nxt = bit_cnt_r + 5'h01;
					end
				end
				acr_pkg::ACR_ST_WRITE, acr_pkg::ACR_ST_READ: begin
					if (bit_cnt_r == 5'h00) begin
						state_nxt = acr_pkg::ACR_ST_CMD;
					end else begin
						bit_cnt_nxt = bit_cnt_r - 5'h01;
					end
				end
				default: begin
					state_nxt   = acr_pkg::ACR_ST_CMD;
					bit_cnt_nxt = 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r   <= acr_pkg::ACR_ST_CMD;
			bit_cnt_r <= 5'h00;
			sel_r     <= acr_pkg::REG_COMM;
			standby_r <= 1'b0;
			sclk_d_r  <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			sel_r     <= sel_nxt;
			standby_r <= standby_nxt;
			sclk_d_r  <= sclk;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			shift_r <= 23'h00_0000;
		end else if (sclk_rise) begin
			shift_r <= wr_word[22:0];
		end
	end

	// Only the configuration word is held here; other registers read back as zero.
	assign rd_bit = (sel_r == acr_pkg::REG_CFG) ? cfg_rd[bit_cnt_r] : 1'b0;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dout_r <= 1'b0;
		end else if (sclk_fall && state_r == acr_pkg::ACR_ST_READ) begin
			dout_r <= rd_bit;
		end
	end

	acr_cfg_bank u_bank (
		.clk       (clk),
		.rst_b     (rst_b),
		.wr_en     (cfg_wr),
		.wr_data   (wr_word),
		.snap_en   (snap),
		.port_c_in (port_c_in),
		.port_d_in (port_d_in),
		.cfg       (cfg),
		.rd_data   (cfg_rd)
	);

	assign dout    = dout_r;
	assign dout_oe = ~cs_b & (state_r == acr_pkg::ACR_ST_READ);
	assign standby = standby_r;

	// Outside standby, writes reach these controls on the next clock; nothing here restarts conversion.
	assign low_switch_b_close = cfg[acr_pkg::F_SW_B] & ~standby_r;
	assign low_switch_a_close = cfg[acr_pkg::F_SW_A] & ~standby_r;

	// A closed switch takes the pin over, so the port driver must let go.
	assign switch_b_pin_out = cfg[acr_pkg::F_B_DAT];
	assign switch_b_pin_oe  = cfg[acr_pkg::F_B_EN] & ~low_switch_b_close;
	assign switch_a_pin_out = cfg[acr_pkg::F_A_DAT];
	assign switch_a_pin_oe  = cfg[acr_pkg::F_A_EN] & ~low_switch_a_close;

	assign route_c = route(cfg[acr_pkg::F_EXC_C +: 2]);
	assign route_b = route(cfg[acr_pkg::F_EXC_B +: 2]);
	assign route_a = route(cfg[acr_pkg::F_EXC_A +: 2]);

	assign excite_c_to_pin_a = route_c[0];
	assign excite_c_to_pin_b = route_c[1];
	assign excite_b_to_pin_a = route_b[0];
	assign excite_b_to_pin_b = route_b[1];
	assign excite_a_to_pin_a = route_a[0];
	assign excite_a_to_pin_b = route_a[1];

	assign analog_config = cfg[7:0];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	cfg_select_a: assert property (cfg_wr |-> sel_r == acr_pkg::REG_CFG && $past(state_r) == acr_pkg::ACR_ST_WRITE)
		else $error("configuration written under another select code");

	msb_first_a: assert property (
		(state_r == acr_pkg::ACR_ST_READ && sel_r == acr_pkg::REG_CFG && sclk_fall && bit_cnt_r == acr_pkg::LAST_CFG)
		|=> dout == cfg_rd[23])
		else $error("configuration read did not start with bit 23");

	no_restart_a: assert property (cfg_wr |=> standby == $past(standby) && state_r == acr_pkg::ACR_ST_CMD)
		else $error("configuration write disturbed converter state");

	write_now_a: assert property (
		cfg_wr && !standby_r
		|=> low_switch_b_close == $past(wr_word[23]) && analog_config == $past(wr_word[7:0]))
		else $error("configuration write not applied on next clock");

	switch_a_a: assert property (
		!standby_r |-> low_switch_a_close == cfg[acr_pkg::F_SW_A] && !(low_switch_a_close && switch_a_pin_oe))
		else $error("first switch does not follow its control bit");

	standby_open_a: assert property (standby_r |-> !low_switch_a_close && !low_switch_b_close)
		else $error("switch closed in standby");

	route_c_a: assert property (cfg[21:20] == 2'b10 |-> excite_c_to_pin_b && !excite_c_to_pin_a)
		else $error("third current misrouted");

	route_b_a: assert property (cfg[19:18] == 2'b01 |-> excite_b_to_pin_a && !excite_b_to_pin_b)
		else $error("second current misrouted");

	route_a_a: assert property (cfg[17:16] == 2'b00 |-> !excite_a_to_pin_a && !excite_a_to_pin_b)
		else $error("first current not off");

	reserved_off_a: assert property (
		(cfg[17:16] == 2'b11 || cfg[19:18] == 2'b11 || cfg[21:20] == 2'b11) |->
		(cfg[17:16] != 2'b11 || (!excite_a_to_pin_a && !excite_a_to_pin_b)) &&
		(cfg[19:18] != 2'b11 || (!excite_b_to_pin_a && !excite_b_to_pin_b)) &&
		(cfg[21:20] != 2'b11 || (!excite_c_to_pin_a && !excite_c_to_pin_b)))
		else $error("reserved code drives a current");

	cfg_write_c: cover property (cfg_wr);
	cfg_read_c: cover property (snap && sel_nxt == acr_pkg::REG_CFG);
	standby_hold_c: cover property (standby_r && cfg[acr_pkg::F_SW_B]);
	reserved_c: cover property (cfg[21:20] == 2'b11);

endmodule : acr_config_port

`default_nettype wire

// File: sim/acr_host_model.sv
// Host model: drives the four-wire serial port of the configuration block.
// Assumes clk is the block's clock and that callers wait for each frame to end.
`timescale 1ns/1ps
`default_nettype none

module acr_host_model (
	input  wire logic clk,
	output logic      cs_b,
	output logic      sclk,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	// Three clk cycles a phase keep every serial level above the two-cycle minimum.
	localparam int unsigned PHASE = 3;
	// No conversion results pass this port, so the settling discard stays a count only.
	localparam int unsigned DISCARD_RESULTS = 3;

	initial begin
		cs_b = 1'b1;
		sclk = 1'b1;
		din  = 1'b0;
	end

	// Shifts tx[n-1:0] most significant first; a short n leaves the frame cut off.
	task automatic frame(input logic [39:0] tx, input int unsigned n, output logic [39:0] rx);
		rx = '0;
		@(posedge clk);
		cs_b <= 1'b0;
		for (int i = int'(n) - 1; i >= 0; i--) begin
			repeat (PHASE) @(posedge clk);
			sclk <= 1'b0;
			din  <= tx[i];
			repeat (PHASE) @(posedge clk);
			rx[i] = dout_oe ? dout : 1'b0;
			sclk <= 1'b1;
		end
		repeat (PHASE) @(posedge clk);
		cs_b <= 1'b1;
		// A released data line must not keep showing the last bit.
		din <= ~din;
		repeat (PHASE) @(posedge clk);
	endtask : frame

endmodule : acr_host_model
`default_nettype wire

// File: sim/tb.sv
// Testbench for the configuration port: host frames in, switch and excitation outputs checked.
// Assumes the host model in acr_host_model.sv and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk, rst_b, port_c_in, port_d_in;
	logic        cs_b, sclk, din, dout, dout_oe, standby;
	logic        low_switch_a_close, low_switch_b_close;
	logic        switch_a_pin_out, switch_a_pin_oe, switch_b_pin_out, switch_b_pin_oe;
	logic        excite_a_to_pin_a, excite_a_to_pin_b, excite_b_to_pin_a, excite_b_to_pin_b;
	logic        excite_c_to_pin_a, excite_c_to_pin_b;
	logic [7:0]  analog_config;
	logic [39:0] rx;
	logic [23:0] cfg_exp;
	logic [23:0] words [4] = '{24'hc6_ff5a, 24'h9b_23a5, 24'h6c_1e07, 24'h31_80ff};
	int          n_fail, total_checks;

	acr_config_port dut (.clk, .rst_b, .cs_b, .sclk, .din, .dout, .dout_oe, .port_c_in, .port_d_in,
		.standby, .low_switch_a_close, .low_switch_b_close, .switch_a_pin_out, .switch_a_pin_oe,
		.switch_b_pin_out, .switch_b_pin_oe, .excite_a_to_pin_a, .excite_a_to_pin_b,
		.excite_b_to_pin_a, .excite_b_to_pin_b, .excite_c_to_pin_a, .excite_c_to_pin_b, .analog_config);

	acr_host_model host (.clk, .cs_b, .sclk, .din, .dout, .dout_oe);

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Expected pin outputs; a closed switch overrides the pin's own output enable.
	function automatic logic [23:0] outs(input logic [23:0] c, input logic s);
		logic ca, cb;
		ca = c[22] & ~s;
		cb = c[23] & ~s;
		return {3'h0, s, ca, cb, c[8], c[12] & ~ca, c[9], c[13] & ~cb,
			c[17:16] == 2'b01, c[17:16] == 2'b10, c[19:18] == 2'b01, c[19:18] == 2'b10,
			c[21:20] == 2'b01, c[21:20] == 2'b10, c[7:0]};
	endfunction : outs

	function automatic logic [23:0] got_outs();
		return {3'h0, standby, low_switch_a_close, low_switch_b_close, switch_a_pin_out, switch_a_pin_oe,
			switch_b_pin_out, switch_b_pin_oe, excite_a_to_pin_a, excite_a_to_pin_b, excite_b_to_pin_a,
			excite_b_to_pin_b, excite_c_to_pin_a, excite_c_to_pin_b, analog_config};
	endfunction : got_outs

	// Port input bits read back only while their pins are set to digital.
	task automatic chk_read(input logic [23:0] c);
		host.frame(40'({8'h41, 24'h5a_a5a5}), 32, rx);
		chk(rx[23:0], {c[23:12], c[15] & port_d_in, c[14] & port_c_in, c[9:0]}, "read back");
	endtask : chk_read

	initial begin
		rst_b     = 1'b0;
		port_c_in = 1'b1;
		port_d_in = 1'b0;
		n_fail    = 0;
		total_checks = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(got_outs(), outs(24'h00_0007, 1'b0), "reset outputs");
		chk_read(24'h00_0007);
		for (int k = 0; k < 4; k++) begin
			port_d_in <= k[0];
			host.frame(40'({8'h01, words[k]}), 32, rx);
			chk(got_outs(), outs(words[k], 1'b0), "routing");
			chk_read(words[k]);
		end
		host.frame(40'({8'h21, 24'hc0_3300}), 32, rx);
		chk(got_outs(), outs(24'hc0_3300, 1'b1), "standby");
		chk_read(24'hc0_3300);
		chk(got_outs(), outs(24'hc0_3300, 1'b0), "awake");
		host.frame(40'({8'h01, 12'h000}), 20, rx);
		chk_read(24'hc0_3300);
		cfg_exp = 24'h05_0003;
		host.frame(40'({1'b1, 8'h01, cfg_exp}), 33, rx);
		chk(got_outs(), outs(cfg_exp, 1'b0), "wait bit");
		host.frame(40'({8'h02, 8'hff}), 16, rx);
		host.frame(40'({8'h03, 16'hffff}), 24, rx);
		chk_read(cfg_exp);
		host.frame(40'({8'h43, 16'h0000}), 24, rx);
		chk(rx[23:0], 24'h00_0000, "data select read");
		// A command byte alone may enter standby; the status read that follows wakes the port again.
		host.frame(40'(8'h20), 8, rx);
		chk(got_outs(), outs(cfg_exp, 1'b1), "command only standby");
		host.frame(40'({8'h40, 8'hff}), 16, rx);
		chk(rx[23:0], 24'h00_0000, "status select read");
		chk(got_outs(), outs(cfg_exp, 1'b0), "status awake");
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("mismatch at %0t: run did not finish", $time);
		wrap_up();
	end

endmodule : tb
`default_nettype wire
